//--- hw/rtc_cfg.svh
// Constants for the supply, alarm and event status block.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_STATUS 8'h04
`define RTC_OFS_BATCFG 8'h08
`define RTC_OFS_ALM0_LO 8'h0C
`define RTC_OFS_ALM0_HI 8'h10
`define RTC_OFS_ALM1_LO 8'h14
`define RTC_OFS_ALM1_HI 8'h18
`define RTC_OFS_FIRST_LO 8'h1C
`define RTC_OFS_FIRST_HI 8'h20
`define RTC_OFS_EV_IDX 8'h24
`define RTC_OFS_EV_LO 8'h28
`define RTC_OFS_EV_HI 8'h2C

// ****************************************
// Control register fields
// ****************************************
`define RTC_CTRL_ALM_EN 1:0
`define RTC_CTRL_PULSE 2
`define RTC_CTRL_EV_EN 3
`define RTC_CTRL_EV_BK 4
`define RTC_CTRL_BUS_BK 5
`define RTC_CTRL_BO_SEL 8:6
`define RTC_CTRL_FSEL 11:9
`define RTC_CTRL_W 12
`define RTC_CTRL_RST 12'h000

// ****************************************
// Status, index and alarm fields
// ****************************************
`define RTC_ST_ALM 1:0
`define RTC_ST_EVT 2
`define RTC_ST_LBAT85 3
`define RTC_ST_LBAT75 4
`define RTC_ST_BROWN 5
`define RTC_ST_BACKUP 6
`define RTC_ST_FIRST 7
`define RTC_IDX_CLR_FIRST 4
`define RTC_ALM_MASK 21:16
`define RTC_BATCFG_RST 6'h0
`define RTC_BO_LEVELS 6
`define RTC_EV_DEPTH 3

// ****************************************
// Timing
// ****************************************
`define RTC_PULSE_MS 250
`define RTC_CLK_KHZ 25000
`define RTC_PULSE_CYC (`RTC_PULSE_MS * `RTC_CLK_KHZ)
`define RTC_PULSE_W 23
`define RTC_NSYNC 15

`endif

//--- hw/rtc_pkg.sv
// Types shared by the supply, alarm and event status block.
// Assumes the constant header is on the include path.
`include "rtc_cfg.svh"

package rtc_pkg;

  // Calendar snapshot, one BCD byte per field
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtc_time_t;

  // Synchronised pin inputs, in sampling order
  typedef struct packed {
    logic timebase;
    logic event_in;
    logic below_bat_hys;
    logic below_trip;
    logic above_bat_hys;
    logic above_trip_hys;
    logic bat_below_85;
    logic bat_below_75;
    logic [5:0] vdd_below_lvl;
    logic spare;
  } rtc_pins_t;

endpackage

//--- hw/rtc_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none

module rtc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate

endmodule

`default_nettype wire

//--- hw/rtc_freq_out.sv
// Frequency output divider driven by timebase edge pulses.
// Assumes tick is a one-cycle pulse on pclk per rising timebase edge.
`timescale 1ns/1ps
`default_nettype none

module rtc_freq_out (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick, // Timebase edge pulse
  input wire logic [2:0] sel, // 0 off, 1..7 frequency taps
  output logic freq_out // Divided clock
);

  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [3:0] tap;
  logic freq_next;

  // Seven taps, one octave pair apart
  assign tap = {sel, 1'b0} - 4'h2;
  assign div_next = tick ? div_reg + 16'h0001 : div_reg;
  assign freq_next = (sel != 3'h0) & div_reg[tap];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
      freq_out <= 1'b0;
    end else begin
      div_reg <= div_next;
      freq_out <= freq_next;
    end
  end

endmodule

`default_nettype wire

//--- hw/rtc_status_top.sv
// Alarm, event time stamp, supply monitor and backup switch logic.
// Assumes an APB master, a calendar feeding now_time on pclk,
// and analogue comparators whose results arrive asynchronously.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_status_top
  import rtc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `RTC_PULSE_CYC
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire rtc_time_t now_time, // Current calendar value
  input wire logic timebase_in, // Timekeeping timebase pin
  input wire logic event_in, // Event input pin
  input wire logic cmp_below_bat_hys, // Supply below backup minus hyst
  input wire logic cmp_below_trip, // Supply below trip level
  input wire logic cmp_above_bat_hys, // Supply above backup plus hyst
  input wire logic cmp_above_trip_hys, // Supply above trip plus hyst
  input wire logic bat_below_85, // Battery below first level
  input wire logic bat_below_75, // Battery below second level
  input wire logic [5:0] vdd_below_lvl, // Supply below each brownout level
  output logic irq_n_o, // Interrupt pin drive value
  output logic irq_n_oe, // Interrupt pin pull-down enable
  output logic low_supply_n_o, // Low-supply pin drive value
  output logic low_supply_n_oe, // Low-supply pin pull-down enable
  output logic event_detect_n_o, // Event-detect pin drive value
  output logic event_detect_n_oe, // Event-detect pin pull-down enable
  output logic freq_out, // Frequency output
  output logic bus_active, // Serial clock and data pins enabled
  output logic backup_mode, // Running from backup supply
  output logic [5:0] battery_level_cfg // Battery trip code to comparators
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  rtc_pins_t pin_raw;
  rtc_pins_t pin;
  logic [`RTC_NSYNC-1:0] pin_vec;

  assign pin_raw = '{timebase: timebase_in, event_in: event_in,
    below_bat_hys: cmp_below_bat_hys, below_trip: cmp_below_trip,
    above_bat_hys: cmp_above_bat_hys, above_trip_hys: cmp_above_trip_hys,
    bat_below_85: bat_below_85, bat_below_75: bat_below_75,
    vdd_below_lvl: vdd_below_lvl, spare: 1'b0};

  rtc_sync #(.W(`RTC_NSYNC)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pin_raw),
    .q(pin_vec)
  );
  assign pin = pin_vec;

  // ****************************************
  // Registers
  // ****************************************
  logic [`RTC_CTRL_W-1:0] ctrl_reg;
  logic [5:0] batcfg_reg;
  logic [31:0] alm_lo_reg [2];
  logic [21:0] alm_hi_reg [2];
  logic [1:0] alm_flag_reg;
  logic evt_flag_reg;
  logic [2:0] ev_idx_reg;
  rtc_time_t first_reg;
  logic first_valid_reg;
  rtc_time_t ev_mem [`RTC_EV_DEPTH];
  logic [1:0] ev_wp_reg;
  logic backup_reg;
  logic tb_d_reg;
  logic ev_d_reg;
  logic [1:0] alm_d_reg;
  logic [`RTC_PULSE_W-1:0] pulse_reg;

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic wr_en;
  logic [31:0] rd_mux;
  logic mapped;
  logic wr_ctrl, wr_stat, wr_bat, wr_idx;
  logic [3:0] wr_alm;

  assign access = psel & penable;
  assign wr_en = access & pwrite & pready;
  assign wr_ctrl = wr_en & (paddr == `RTC_OFS_CTRL);
  assign wr_stat = wr_en & (paddr == `RTC_OFS_STATUS);
  assign wr_bat = wr_en & (paddr == `RTC_OFS_BATCFG);
  assign wr_idx = wr_en & (paddr == `RTC_OFS_EV_IDX);
  assign wr_alm = {wr_en & (paddr == `RTC_OFS_ALM1_HI), wr_en & (paddr == `RTC_OFS_ALM1_LO),
    wr_en & (paddr == `RTC_OFS_ALM0_HI), wr_en & (paddr == `RTC_OFS_ALM0_LO)};

  // ****************************************
  // Power switch and supply monitors
  // ****************************************
  logic backup_next;
  logic brown;
  logic [2:0] bo_sel;
  logic [7:0] status_word;

  assign backup_next = backup_reg
    ? ~(pin.above_bat_hys | pin.above_trip_hys)
    : (pin.below_bat_hys & pin.below_trip);
  assign bo_sel = ctrl_reg[`RTC_CTRL_BO_SEL];
  assign brown = (bo_sel < 3'(`RTC_BO_LEVELS)) & pin.vdd_below_lvl[bo_sel];

  // ****************************************
  // Alarm matching
  // ****************************************
  logic [1:0] alm_match;
  logic [1:0] alm_hit;
  logic pulse_mode;

  assign pulse_mode = ctrl_reg[`RTC_CTRL_PULSE];

  genvar a;
  generate
    for (a = 0; a < 2; a++) begin : g_alm
      logic [5:0] eq;
      logic [5:0] mask;
      assign mask = alm_hi_reg[a][`RTC_ALM_MASK];
      assign eq = {now_time.year == alm_hi_reg[a][15:8],
        now_time.month == alm_hi_reg[a][7:0],
        now_time.date == alm_lo_reg[a][31:24],
        now_time.hour == alm_lo_reg[a][23:16],
        now_time.min == alm_lo_reg[a][15:8],
        now_time.sec == alm_lo_reg[a][7:0]};
      assign alm_match[a] = (|mask) & (&(~mask | eq));
      // Once per match window, not while it persists
      assign alm_hit[a] = alm_match[a] & ~alm_d_reg[a] & ctrl_reg[a] & ~backup_reg;
    end
  endgenerate

  logic [1:0] alm_flag_next;
  logic [`RTC_PULSE_W-1:0] pulse_next;
  logic irq_next;

  // Set wins over a write of zero
  assign alm_flag_next = alm_hit
    | (alm_flag_reg & ~(wr_stat ? ~pwdata[`RTC_ST_ALM] : 2'b00));
  assign pulse_next = (pulse_mode & |alm_hit) ? `RTC_PULSE_W'(PULSE_CYC - 1)
    : (pulse_reg != '0) ? pulse_reg - 1'b1 : pulse_reg;
  assign irq_next = pulse_mode ? ((pulse_reg != '0) | (|alm_hit))
    : (|alm_flag_next);

  // ****************************************
  // Event detection and time stamps
  // ****************************************
  logic ev_gate;
  logic ev_rise;
  logic evt_flag_next;
  logic [1:0] ev_wp_next;
  logic [2:0] rd_slot;
  rtc_time_t ev_rd;

  assign ev_gate = pin.event_in & ctrl_reg[`RTC_CTRL_EV_EN]
    & (~backup_reg | ctrl_reg[`RTC_CTRL_EV_BK]);
  assign ev_rise = ev_gate & ~ev_d_reg;
  assign evt_flag_next = ev_rise | (evt_flag_reg & ~(wr_stat & ~pwdata[`RTC_ST_EVT]));
  assign ev_wp_next = (ev_wp_reg == 2'h2) ? 2'h0 : ev_wp_reg + 2'h1;
  // Index 0 is the newest stamp
  assign rd_slot = ({1'b0, ev_wp_reg} + 3'h2 - ev_idx_reg) >= 3'h3
    ? {1'b0, ev_wp_reg} + 3'h2 - ev_idx_reg - 3'h3
    : {1'b0, ev_wp_reg} + 3'h2 - ev_idx_reg;
  assign ev_rd = (ev_idx_reg < 3'(`RTC_EV_DEPTH)) ? ev_mem[rd_slot[1:0]] : '0;

  // ****************************************
  // Read multiplexer
  // ****************************************
  assign status_word = {first_valid_reg, backup_reg, brown, pin.bat_below_75,
    pin.bat_below_85 | pin.bat_below_75, evt_flag_reg, alm_flag_reg};

  always_comb begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    if (paddr == `RTC_OFS_CTRL) begin
      rd_mux = {20'h00000, ctrl_reg};
    end else if (paddr == `RTC_OFS_STATUS) begin
      rd_mux = {24'h000000, status_word};
    end else if (paddr == `RTC_OFS_BATCFG) begin
      rd_mux = {26'h0, batcfg_reg};
    end else if (paddr == `RTC_OFS_ALM0_LO) begin
      rd_mux = alm_lo_reg[0];
    end else if (paddr == `RTC_OFS_ALM0_HI) begin
      rd_mux = {10'h0, alm_hi_reg[0]};
    end else if (paddr == `RTC_OFS_ALM1_LO) begin
      rd_mux = alm_lo_reg[1];
    end else if (paddr == `RTC_OFS_ALM1_HI) begin
      rd_mux = {10'h0, alm_hi_reg[1]};
    end else if (paddr == `RTC_OFS_FIRST_LO) begin
      rd_mux = first_reg[31:0];
    end else if (paddr == `RTC_OFS_FIRST_HI) begin
      rd_mux = {16'h0000, first_reg[47:32]};
    end else if (paddr == `RTC_OFS_EV_IDX) begin
      rd_mux = {29'h0, ev_idx_reg};
    end else if (paddr == `RTC_OFS_EV_LO) begin
      rd_mux = ev_rd[31:0];
    end else if (paddr == `RTC_OFS_EV_HI) begin
      rd_mux = {16'h0000, ev_rd[47:32]};
    end else begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // APB response, one wait state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata <= (access & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RTC_CTRL_RST;
      batcfg_reg <= `RTC_BATCFG_RST;
      ev_idx_reg <= 3'h0;
      for (int i = 0; i < 2; i++) begin
        alm_lo_reg[i] <= 32'h00000000;
        alm_hi_reg[i] <= 22'h0;
      end
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[`RTC_CTRL_W-1:0];
      if (wr_bat) batcfg_reg <= pwdata[5:0];
      if (wr_idx) ev_idx_reg <= pwdata[2:0];
      for (int i = 0; i < 2; i++) begin
        if (wr_alm[2*i]) alm_lo_reg[i] <= pwdata;
        if (wr_alm[2*i+1]) alm_hi_reg[i] <= pwdata[21:0];
      end
    end
  end

  // ****************************************
  // Block state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_reg <= 1'b0;
      tb_d_reg <= 1'b0;
      ev_d_reg <= 1'b0;
      alm_d_reg <= 2'b00;
      alm_flag_reg <= 2'b00;
      evt_flag_reg <= 1'b0;
      pulse_reg <= '0;
      ev_wp_reg <= 2'h0;
    end else begin
      backup_reg <= backup_next;
      tb_d_reg <= pin.timebase;
      ev_d_reg <= ev_gate;
      alm_d_reg <= alm_match;
      alm_flag_reg <= alm_flag_next;
      evt_flag_reg <= evt_flag_next;
      pulse_reg <= pulse_next;
      if (ev_rise) ev_wp_reg <= ev_wp_next;
    end
  end

  // Whole snapshot taken in one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reg <= '0;
      first_valid_reg <= 1'b0;
      for (int i = 0; i < `RTC_EV_DEPTH; i++) begin
        ev_mem[i] <= '0;
      end
    end else begin
      if (ev_rise) ev_mem[ev_wp_reg] <= now_time;
      if (ev_rise & ~first_valid_reg) begin
        first_reg <= now_time;
        first_valid_reg <= 1'b1;
      end else if (wr_idx & pwdata[`RTC_IDX_CLR_FIRST]) begin
        first_valid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  rtc_freq_out u_freq_out (
    .clk(pclk),
    .rst_n(presetn),
    .tick(pin.timebase & ~tb_d_reg),
    .sel(ctrl_reg[`RTC_CTRL_FSEL]),
    .freq_out(freq_out)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_o <= 1'b0;
      irq_n_oe <= 1'b0;
      low_supply_n_o <= 1'b0;
      low_supply_n_oe <= 1'b0;
      event_detect_n_o <= 1'b0;
      event_detect_n_oe <= 1'b0;
      bus_active <= 1'b0;
      backup_mode <= 1'b0;
      battery_level_cfg <= `RTC_BATCFG_RST;
    end else begin
      irq_n_oe <= irq_next;
      low_supply_n_oe <= brown;
      event_detect_n_oe <= evt_flag_next;
      bus_active <= ~backup_next | ctrl_reg[`RTC_CTRL_BUS_BK];
      backup_mode <= backup_next;
      battery_level_cfg <= batcfg_reg;
    end
  end

endmodule

`default_nettype wire

//--- verif/rtc_status_props.sv
// Port checker for the status block.
// Assumes binding onto rtc_status_top in one clock domain.
`timescale 1ns/1ps
`default_nettype none

module rtc_status_props #(
  parameter int unsigned PULSE_CYC = 20
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [31:0] prdata, // Read data
  input wire logic event_in, // Event pin
  input wire logic cmp_below_bat_hys, // Comparator
  input wire logic cmp_below_trip, // Comparator
  input wire logic cmp_above_bat_hys, // Comparator
  input wire logic cmp_above_trip_hys, // Comparator
  input wire logic irq_n_o, // Drive value
  input wire logic low_supply_n_o, // Drive value
  input wire logic event_detect_n_o, // Drive value
  input wire logic event_detect_n_oe, // Pull-down enable
  input wire logic bus_active, // Serial pins on
  input wire logic backup_mode, // On backup
  input wire logic [5:0] battery_level_cfg // Trip code
);
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a ready cycle");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  od_value_a: assert property (!irq_n_o && !low_supply_n_o && !event_detect_n_o)
    else $error("open-drain value not low");
  enter_backup_a: assert property ($rose(backup_mode) |->
    $past(cmp_below_bat_hys, 3) && $past(cmp_below_trip, 3))
    else $error("backup entered without both comparators");
  leave_backup_a: assert property ($fell(backup_mode) |->
    $past(cmp_above_bat_hys, 3) || $past(cmp_above_trip_hys, 3))
    else $error("backup left without a comparator");
  bus_restore_a: assert property ($fell(backup_mode) |-> ##[0:1] bus_active)
    else $error("bus not restored after backup");
  detect_cause_a: assert property ($rose(event_detect_n_oe) |-> $past(event_in, 3))
    else $error("detect without synchronised event");
  cfg_write_a: assert property ($changed(battery_level_cfg) |-> $past(pready && pwrite, 2))
    else $error("battery code changed without write");
endmodule

bind rtc_status_top rtc_status_props #(.PULSE_CYC(PULSE_CYC)) u_rtc_status_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .prdata, .event_in,
  .cmp_below_bat_hys, .cmp_below_trip, .cmp_above_bat_hys, .cmp_above_trip_hys,
  .irq_n_o, .low_supply_n_o, .event_detect_n_o, .event_detect_n_oe, .bus_active,
  .backup_mode, .battery_level_cfg
);

`default_nettype wire

//--- verif/rtc_host_mdl.sv
// Host side of the open-drain pins, with board pull-ups.
// Assumes drive value and enable pairs from the status block.
`timescale 1ns/1ps
`default_nettype none

module rtc_host_mdl (
  input wire logic irq_o, // Interrupt value
  input wire logic irq_oe, // Interrupt enable
  input wire logic ls_o, // Low-supply value
  input wire logic ls_oe, // Low-supply enable
  input wire logic ed_o, // Detect value
  input wire logic ed_oe, // Detect enable
  output logic irq_pin, // Resolved level
  output logic ls_pin, // Resolved level
  output logic ed_pin // Resolved level
);
  // Released pins float up to the pull-up
  assign irq_pin = irq_oe ? irq_o : 1'b1;
  assign ls_pin = ls_oe ? ls_o : 1'b1;
  assign ed_pin = ed_oe ? ed_o : 1'b1;
endmodule

`default_nettype wire

//--- verif/rtc_status_top_tb.sv
// Self-checking bench for the status block.
// Assumes design files, checker and host model compiled first.
`timescale 1ns/1ps
`default_nettype none

module rtc_status_top_tb;
  import rtc_pkg::*;
  localparam int unsigned PC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h145F13BB;
  logic pready, pslverr, perr, freq_out, fo_q, bus_active, backup_mode, event_in = 1'b0;
  logic tb_clk = 1'b0, cbh = 1'b0, ctr = 1'b0, cah = 1'b0, cth = 1'b0, b85 = 1'b0, b75 = 1'b0;
  logic [5:0] vdd = 6'h00, battery_level_cfg;
  logic irq_o, irq_oe, ls_o, ls_oe, ed_o, ed_oe, irq_pin, ls_pin, ed_pin;
  rtc_time_t now = 48'h0, t1, t2;
  int error_cnt = 0, num_checks = 0, n;

  always #20 pclk = ~pclk;
  initial begin
    #13;
    forever #160 tb_clk = ~tb_clk;
  end

  rtc_status_top #(.PULSE_CYC(PC)) u_rtc_status_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .now_time(now), .timebase_in(tb_clk), .event_in, .cmp_below_bat_hys(cbh),
    .cmp_below_trip(ctr), .cmp_above_bat_hys(cah), .cmp_above_trip_hys(cth),
    .bat_below_85(b85), .bat_below_75(b75), .vdd_below_lvl(vdd), .irq_n_o(irq_o),
    .irq_n_oe(irq_oe), .low_supply_n_o(ls_o), .low_supply_n_oe(ls_oe),
    .event_detect_n_o(ed_o), .event_detect_n_oe(ed_oe), .freq_out, .bus_active,
    .backup_mode, .battery_level_cfg
  );
  rtc_host_mdl u_rtc_host_mdl (
    .irq_o, .irq_oe, .ls_o, .ls_oe, .ed_o, .ed_oe, .irq_pin, .ls_pin, .ed_pin
  );

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_ls(input logic [2:0] s, input logic [5:0] v);
    return (s < 3'h6) && v[s];
  endfunction
  function automatic int exp_tg(input int s);
    return (s == 0) ? 0 : 10 >> (2 * (s - 1));
  endfunction
  task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 16) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic pulse_ev();
    event_in <= 1'b1;
    cyc(10);
    event_in <= 1'b0;
    cyc(4);
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    cyc(5);
    presetn <= 1'b1;
    apb(0, 8'h04, 32'h0);
    chk("status", rd, 32'h0);
    apb(0, 8'h30, 32'h0);
    chk("unmapped", {perr, rd}, 33'h100000000);
    lfsr = nxt(lfsr);
    apb(1, 8'h08, {26'h0, lfsr[5:0]});
    cyc(1);
    chk("batcfg", battery_level_cfg, lfsr[5:0]);
    b85 <= 1'b1;
    cyc(6);
    apb(0, 8'h04, 32'h0);
    chk("lbat85", rd[4:3], 2'b01);
    b75 <= 1'b1;
    cyc(6);
    apb(0, 8'h04, 32'h0);
    chk("lbat75", rd[4:3], 2'b11);
    for (int s = 0; s < 8; s++) begin
      lfsr = nxt(lfsr);
      vdd <= lfsr[5:0];
      apb(1, 8'h00, 32'(s) << 6);
      cyc(5);
      chk("brownout", ls_oe, exp_ls(3'(s), vdd));
      chk("low pin", ls_pin, !exp_ls(3'(s), vdd));
      apb(0, 8'h04, 32'h0);
      chk("brown bit", rd[5], exp_ls(3'(s), vdd));
    end
    $display("supply test done");
    lfsr = nxt(lfsr);
    t1 = {lfsr[15:0], lfsr};
    now <= ~t1;
    apb(1, 8'h0C, t1[31:0]);
    apb(1, 8'h10, {10'h0, 6'h3F, t1[47:32]});
    apb(1, 8'h00, 32'h1);
    now <= t1 ^ 48'h1;
    cyc(4);
    chk("near miss", irq_oe, 1'b0);
    now <= t1;
    cyc(4);
    chk("irq", {irq_oe, irq_pin}, 2'b10);
    apb(0, 8'h04, 32'h0);
    chk("alarm flag", rd[1:0], 2'b01);
    apb(1, 8'h04, 32'h0);
    cyc(2);
    chk("irq clear", irq_oe, 1'b0);
    now <= {t1[47:8], ~t1[7:0]};
    apb(1, 8'h18, 32'h00010000);
    apb(1, 8'h14, {24'h0, t1[7:0]});
    apb(1, 8'h00, 32'h6);
    for (int r = 0; r < 2; r++) begin
      now <= {t1[47:8], ~t1[7:0]};
      cyc(2);
      now <= {t1[47:16], 8'(r), t1[7:0]};
      n = 0;
      repeat (40) begin
        @(posedge pclk);
        if (irq_oe === 1'b1)
          n++;
      end
      chk("pulse len", n, PC);
    end
    apb(0, 8'h04, 32'h0);
    chk("alarm1 flag", rd[1], 1'b1);
    $display("alarm test done");
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h00, 32'h8);
    now <= t1;
    pulse_ev();
    chk("detect", {ed_oe, ed_pin}, 2'b10);
    apb(0, 8'h04, 32'h0);
    chk("event flags", {rd[7], rd[2]}, 2'b11);
    apb(0, 8'h1C, 32'h0);
    chk("first lo", rd, t1[31:0]);
    apb(0, 8'h20, 32'h0);
    chk("first hi", rd, {16'h0, t1[47:32]});
    apb(1, 8'h04, 32'h0);
    cyc(2);
    chk("detect clr", ed_oe, 1'b0);
    lfsr = nxt(lfsr);
    t2 = {lfsr, lfsr[31:16]};
    now <= t2;
    pulse_ev();
    apb(0, 8'h1C, 32'h0);
    chk("first kept", rd, t1[31:0]);
    for (int i = 0; i < 2; i++) begin
      apb(1, 8'h24, 32'(i));
      apb(0, 8'h28, 32'h0);
      chk("ring", rd, (i == 0) ? t2[31:0] : t1[31:0]);
    end
    apb(1, 8'h24, 32'h10);
    apb(0, 8'h04, 32'h0);
    chk("first clr", rd[7], 1'b0);
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h00, 32'h0);
    pulse_ev();
    apb(0, 8'h04, 32'h0);
    chk("gated", {ed_oe, rd[2]}, 2'b00);
    $display("event test done");
    cbh <= 1'b1;
    cyc(6);
    chk("one cmp", backup_mode, 1'b0);
    for (int j = 0; j < 2; j++) begin
      {cbh, ctr, cah, cth} <= 4'b1100;
      cyc(6);
      chk("backup", {backup_mode, bus_active}, 2'b10);
      apb(0, 8'h04, 32'h0);
      chk("backup bit", rd[6], 1'b1);
      apb(1, 8'h00, 32'h38);
      cyc(2);
      chk("bus bk", bus_active, 1'b1);
      pulse_ev();
      chk("event bk", ed_oe, 1'b1);
      apb(1, 8'h00, 32'h0);
      apb(1, 8'h04, 32'h0);
      {cbh, ctr, cah, cth} <= {2'b00, 2'(j + 1)};
      cyc(6);
      chk("resume", {backup_mode, bus_active}, 2'b01);
    end
    $display("power test done");
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h00, 32'(s) << 9);
      cyc(4);
      n = 0;
      fo_q = freq_out;
      repeat (80) begin
        @(posedge pclk);
        if (freq_out !== fo_q)
          n++;
        fo_q = freq_out;
      end
      chk("freq", (n >= exp_tg(s) - 1) && (n <= exp_tg(s) + 1), 1'b1);
    end
    $display("frequency test done");
    wrap_up();
  end
endmodule

`default_nettype wire
